// ===== sbc_mode_defs.vh
// constants of the operating mode controller: offsets, fields, codes, times
`ifndef SBC_MODE_DEFS_VH
`define SBC_MODE_DEFS_VH

// serial register addresses (7-bit)
`define ADDR_MODE_SELECT   7'h01
`define ADDR_MAIN_STATUS   7'h03
`define ADDR_EVENT_ENABLE  7'h04
`define ADDR_WDOG_STATUS   7'h05
`define ADDR_SUPPLY_CTRL   7'h10
`define ADDR_EVENT_STATUS  7'h61
`define ADDR_NV_STATUS     7'h70
`define ADDR_NV_CONFIG     7'h74
`define ADDR_IDENT         7'h7E

// mode select field
`define MODE_FIELD_MSB     2
`define MODE_FIELD_LSB     0
`define MODE_REQ_SLEEP     3'h1
`define MODE_REQ_STANDBY   3'h4
`define MODE_REQ_NORMAL    3'h7
`define MODE_SELECT_RESET  3'h4

// main status fields
`define MAIN_OVERTEMP_WARNING_STATUS_BIT      6
`define MAIN_NMS_BIT       5

// event enable / event status fields
`define EVT_OTW_BIT        2
`define EVT_SPI_FAILURE_EVENT_BIT       1

// supply control fields
`define SUP_CTRL_MSB       2
`define SUP_CTRL_LSB       1
`define SUP_STARTUP_BIT    0
`define SUP_CTRL_OFF       2'h0
`define SUP_CTRL_NORMAL    2'h1
`define SUP_CTRL_ACTIVE    2'h2
`define SUP_CTRL_ALWAYS    2'h3

// non-volatile configuration fields and factory values
`define NV_FORCED_NORMAL_CFG_BIT_BIT        0
`define NV_SLEEP_INHIBIT_BIT_BIT        2
`define NV_FACTORY_VALUE   8'h01
`define NV_STATUS_FACTORY  8'h01

// identification value, arbitrary
`define IDENT_VALUE        8'h5A

// reset cause codes
`define RSS_POWER_ON       5'h00
`define RSS_CAN_WAKE       5'h01
`define RSS_DIAG_WAKE      5'h0D
`define RSS_EXT_RESET      5'h11
`define RSS_LEFT_OTEMP     5'h12
`define RSS_V1_UNDERVOLT   5'h13
`define RSS_ILLEGAL_SLEEP  5'h14

// operating mode state codes
`define ST_OFF             3'h0
`define ST_RESET           3'h1
`define ST_STANDBY         3'h2
`define ST_NORMAL          3'h3
`define ST_SLEEP           3'h4
`define ST_FORCED          3'h5
`define ST_OTEMP           3'h6

// timing: clock rate and times in microseconds
`define CLK_MHZ            100
`define STARTUP_US         1000
`define RESET_PULSE_US     20
`define RESET_PULSE_CYC    (`RESET_PULSE_US * `CLK_MHZ)
// last timer count of the reset pulse, sized to match the timer
`define RESET_PULSE_LAST   17'h007CF

`endif

// ===== spi_frame_slave.v
// serial frame slave: 8-bit address/read-only byte then 8-bit data
`timescale 1ns/1ps
module spi_frame_slave (
  input  wire       clk,
  input  wire       resetn,
  input  wire       sckPin,
  input  wire       sdiPin,
  input  wire       csnPin,
  input  wire [7:0] readData,
  output reg  [6:0] frameAddr,
  output reg        frameReadOnly,
  output reg        addrStrobe,
  output reg        writeStrobe,
  output reg  [7:0] writeData,
  output reg        sdo
);

  reg [2:0] sckSync;
  reg [1:0] sdiSync;
  reg [2:0] csnSync;
  reg [4:0] bitCnt;
  reg [7:0] inShift;
  reg [7:0] outShift;
  wire      sckRise;
  wire      sckFall;
  wire      csnRise;
  wire      csnLow;

  // two-flop synchronisers; edges read stages two and three only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sckSync <= 3'h0;
      sdiSync <= 2'h0;
      csnSync <= 3'h7;
    end else begin
      sckSync <= {sckSync[1:0], sckPin};
      sdiSync <= {sdiSync[0], sdiPin};
      csnSync <= {csnSync[1:0], csnPin};
    end
  end

  assign sckRise = sckSync[1] & ~sckSync[2];
  assign sckFall = ~sckSync[1] & sckSync[2];
  assign csnRise = csnSync[1] & ~csnSync[2];
  assign csnLow  = ~csnSync[1];

  // shift in on rising sck, shift out on falling sck (mode 0)
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt        <= 5'h00;
      inShift       <= 8'h00;
      outShift      <= 8'h00;
      frameAddr     <= 7'h00;
      frameReadOnly <= 1'b1;
      addrStrobe    <= 1'b0;
      writeStrobe   <= 1'b0;
      writeData     <= 8'h00;
      sdo           <= 1'b0;
    end else begin
      addrStrobe  <= 1'b0;
      writeStrobe <= 1'b0;
      if (!csnLow) begin
        bitCnt <= 5'h00;
        sdo    <= 1'b0;
        // only a complete 16-bit frame commits a write
        if (csnRise && bitCnt == 5'h10 && !frameReadOnly)
          writeStrobe <= 1'b1;
      end else begin
        if (sckRise && bitCnt != 5'h10) begin
          inShift <= {inShift[6:0], sdiSync[1]};
          bitCnt  <= bitCnt + 5'h01;
          if (bitCnt == 5'h07) begin
            frameAddr     <= inShift[6:0];
            frameReadOnly <= sdiSync[1];
            addrStrobe    <= 1'b1;
          end
          if (bitCnt == 5'h0F)
            writeData <= {inShift[6:0], sdiSync[1]};
        end
        // read data is latched right after the address byte
        if (addrStrobe)
          outShift <= readData;
        else if (sckFall && bitCnt >= 5'h08 && bitCnt < 5'h10) begin
          sdo      <= outShift[7];
          outShift <= {outShift[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// ===== sbc_operating_mode_controller.v
// operating mode state machine with per-mode supply, reset and bus control
`timescale 1ns/1ps
`include "sbc_mode_defs.vh"

module sbc_operating_mode_controller #(
  parameter STARTUP_CYC = `STARTUP_US * `CLK_MHZ
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       batteryAbovePowerOn,
  input  wire       batteryBelowPowerOff,
  input  wire       tempAboveWarning,
  input  wire       tempAboveShutdown,
  input  wire       tempBelowRelease,
  input  wire       v1Undervoltage,
  input  wire       canSupplyUndervoltage,
  input  wire       wakeRegular,
  input  wire       wakeDiagnostic,
  input  wire       wakePending,
  input  wire       wakeSourceEnabled,
  input  wire       canRxBit,
  input  wire       resetLineIn,
  output wire       resetLineOut,
  output wire       resetLineOe,
  input  wire       sck,
  input  wire       sdi,
  input  wire       csn,
  output wire       sdo,
  output reg        mcuRegulatorEn,
  output reg        auxSupplyEn,
  output reg        canTxEnable,
  output reg        canRxEnable,
  output reg        canBusRelease,
  output reg        receiveLine,
  output reg        watchdogEnable,
  output reg        watchdogWindowEn,
  output reg  [2:0] operatingMode,
  output reg        overtempWarningStatus,
  output reg        overtempWarningEvent,
  output reg        spiFailureEvent
);

  reg  [1:0]  batOnSync, batOffSync, warnSync, otpSync, relSync;
  reg  [1:0]  v1UvSync, canUvSync, wakeRegSync, wakeDiagSync;
  reg  [1:0]  pendSync, srcSync, rstSync;
  reg  [2:0]  mode_q, mode_d;
  reg  [4:0]  cause_q, cause_d;
  reg  [2:0]  modeSel_q;
  reg         normalSeen_q;
  reg  [7:0]  nvConfig_q;
  reg         factory_q;
  reg         otwEnable_q, spifEnable_q;
  reg  [2:0]  supCtrl_q;
  reg  [16:0] timer_q;
  reg         pulseDone_q;
  reg         fromForced_q;
  reg         powerUp_q;
  reg         sleepFail;
  reg  [7:0]  readData;
  reg         readAllowed;
  wire [6:0]  frameAddr;
  wire        frameReadOnly;
  wire        addrStrobe;
  wire        writeStrobe;
  wire [7:0]  writeData;
  wire        spiActive;
  wire        modeWrite;
  wire [2:0]  reqCode;
  wire        extReset;
  wire        supRequest;

  spi_frame_slave serial (
    .clk           (clk),
    .resetn        (resetn),
    .sckPin        (sck),
    .sdiPin        (sdi),
    .csnPin        (csn),
    .readData      (readData),
    .frameAddr     (frameAddr),
    .frameReadOnly (frameReadOnly),
    .addrStrobe    (addrStrobe),
    .writeStrobe   (writeStrobe),
    .writeData     (writeData),
    .sdo           (sdo)
  );

  // two-flop synchronisers for detector and pin inputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      batOnSync  <= 2'h0;  batOffSync   <= 2'h3;
      warnSync   <= 2'h0;  otpSync      <= 2'h0;
      relSync    <= 2'h0;  v1UvSync     <= 2'h0;
      canUvSync  <= 2'h0;  wakeRegSync  <= 2'h0;
      wakeDiagSync <= 2'h0; pendSync    <= 2'h0;
      srcSync    <= 2'h0;  rstSync      <= 2'h0;
    end else begin
      batOnSync    <= {batOnSync[0], batteryAbovePowerOn};
      batOffSync   <= {batOffSync[0], batteryBelowPowerOff};
      warnSync     <= {warnSync[0], tempAboveWarning};
      otpSync      <= {otpSync[0], tempAboveShutdown};
      relSync      <= {relSync[0], tempBelowRelease};
      v1UvSync     <= {v1UvSync[0], v1Undervoltage};
      canUvSync    <= {canUvSync[0], canSupplyUndervoltage};
      wakeRegSync  <= {wakeRegSync[0], wakeRegular};
      wakeDiagSync <= {wakeDiagSync[0], wakeDiagnostic};
      pendSync     <= {pendSync[0], wakePending};
      srcSync      <= {srcSync[0], wakeSourceEnabled};
      rstSync      <= {rstSync[0], resetLineIn};
    end
  end

  // serial port only serves frames in the awake modes
  assign spiActive = (mode_q == `ST_STANDBY) || (mode_q == `ST_NORMAL) ||
                     (mode_q == `ST_FORCED);
  assign modeWrite = writeStrobe && spiActive &&
                     frameAddr == `ADDR_MODE_SELECT;
  assign reqCode   = writeData[`MODE_FIELD_MSB:`MODE_FIELD_LSB];
  // external pull-down seen while the line is not driven by us
  assign extReset  = !rstSync[1] && !resetLineOe;

  always @* begin
    readAllowed = (mode_q != `ST_FORCED) ||
                  frameAddr == `ADDR_MAIN_STATUS ||
                  frameAddr == `ADDR_WDOG_STATUS ||
                  frameAddr == `ADDR_IDENT ||
                  frameAddr == `ADDR_NV_STATUS ||
                  frameAddr == `ADDR_NV_CONFIG;
    readData = 8'h00;
    if (spiActive && readAllowed) begin
      case (frameAddr)
        `ADDR_MODE_SELECT:  readData = {5'h00, modeSel_q};
        `ADDR_MAIN_STATUS:  readData = {1'b0, overtempWarningStatus,
                                        ~normalSeen_q, cause_q};
        `ADDR_EVENT_ENABLE: readData = {5'h00, otwEnable_q,
                                        spifEnable_q, 1'b0};
        `ADDR_EVENT_STATUS: readData = {5'h00, overtempWarningEvent,
                                        spiFailureEvent, 1'b0};
        `ADDR_SUPPLY_CTRL:  readData = {5'h00, supCtrl_q};
        `ADDR_NV_STATUS:    readData = factory_q ? `NV_STATUS_FACTORY
                                                 : 8'h00;
        `ADDR_NV_CONFIG:    readData = nvConfig_q;
        `ADDR_IDENT:        readData = `IDENT_VALUE;
        default:            readData = 8'h00;
      endcase
    end
  end

  // next mode; battery loss outranks everything, then overtemp
  always @* begin
    mode_d    = mode_q;
    cause_d   = cause_q;
    sleepFail = 1'b0;
    case (mode_q)
      `ST_OFF: begin
        if (batOnSync[1] && timer_q == STARTUP_CYC[16:0]) begin
          mode_d  = `ST_RESET;
          cause_d = `RSS_POWER_ON;
        end
      end
      `ST_RESET: begin
        if (pulseDone_q && rstSync[1] && nvConfig_q[`NV_FORCED_NORMAL_CFG_BIT_BIT])
          mode_d = `ST_FORCED;
        else if (pulseDone_q && rstSync[1])
          mode_d = `ST_STANDBY;
      end
      `ST_STANDBY, `ST_NORMAL: begin
        if (v1UvSync[1]) begin
          mode_d  = `ST_RESET;
          cause_d = `RSS_V1_UNDERVOLT;
        end else if (extReset) begin
          mode_d  = `ST_RESET;
          cause_d = `RSS_EXT_RESET;
        end else if (modeWrite) begin
          case (reqCode)
            `MODE_REQ_NORMAL:  mode_d = `ST_NORMAL;
            `MODE_REQ_STANDBY: mode_d = `ST_STANDBY;
            `MODE_REQ_SLEEP: begin
              if (nvConfig_q[`NV_SLEEP_INHIBIT_BIT_BIT])
                sleepFail = 1'b1;
              else if (pendSync[1] || !srcSync[1]) begin
                mode_d  = `ST_RESET;
                cause_d = `RSS_ILLEGAL_SLEEP;
              end else
                mode_d = `ST_SLEEP;
            end
            default: mode_d = mode_q;
          endcase
        end
      end
      `ST_FORCED: begin
        if (v1UvSync[1]) begin
          mode_d  = `ST_RESET;
          cause_d = `RSS_V1_UNDERVOLT;
        end else if (extReset) begin
          mode_d  = `ST_RESET;
          cause_d = `RSS_EXT_RESET;
        end
      end
      `ST_SLEEP: begin
        if (wakeDiagSync[1]) begin
          mode_d  = `ST_RESET;
          cause_d = `RSS_DIAG_WAKE;
        end else if (wakeRegSync[1]) begin
          mode_d  = `ST_RESET;
          cause_d = `RSS_CAN_WAKE;
        end
      end
      `ST_OTEMP: begin
        if (relSync[1]) begin
          mode_d  = `ST_RESET;
          cause_d = `RSS_LEFT_OTEMP;
        end
      end
      default: mode_d = `ST_OFF;
    endcase
    if (otpSync[1] && mode_q != `ST_OFF && mode_q != `ST_SLEEP &&
        mode_q != `ST_OTEMP)
      mode_d = `ST_OTEMP;
    if (batOffSync[1])
      mode_d = `ST_OFF;
  end

  // mode register, reset cause, startup and reset pulse timer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q       <= `ST_OFF;
      cause_q      <= `RSS_POWER_ON;
      modeSel_q    <= `MODE_SELECT_RESET;
      normalSeen_q <= 1'b0;
      timer_q      <= 17'h00000;
      pulseDone_q  <= 1'b0;
      fromForced_q <= 1'b0;
      powerUp_q    <= 1'b1;
    end else begin
      mode_q  <= mode_d;
      cause_q <= cause_d;
      if (mode_d == `ST_NORMAL)
        normalSeen_q <= 1'b1;
      if (mode_d == `ST_NORMAL || mode_d == `ST_STANDBY ||
          mode_d == `ST_SLEEP)
        modeSel_q <= (mode_d == `ST_NORMAL)  ? `MODE_REQ_NORMAL :
                     (mode_d == `ST_STANDBY) ? `MODE_REQ_STANDBY :
                                               `MODE_REQ_SLEEP;
      if (mode_d == `ST_OFF) begin
        normalSeen_q <= 1'b0;
        powerUp_q    <= 1'b1;
      end else if (mode_q == `ST_RESET && mode_d != `ST_RESET)
        powerUp_q <= 1'b0;
      if (mode_d != mode_q) begin
        timer_q      <= 17'h00000;
        pulseDone_q  <= 1'b0;
        fromForced_q <= (mode_q == `ST_FORCED);
      end else if (mode_q == `ST_OFF) begin
        // count only while the battery stays above power-on
        if (!batOnSync[1])
          timer_q <= 17'h00000;
        else if (timer_q != STARTUP_CYC[16:0])
          timer_q <= timer_q + 17'h00001;
      end else if (mode_q == `ST_RESET) begin
        // an undervoltage holds the pulse until v1 recovers
        if (v1UvSync[1])
          timer_q <= 17'h00000;
        else if (timer_q == `RESET_PULSE_LAST)
          pulseDone_q <= 1'b1;
        else
          timer_q <= timer_q + 17'h00001;
      end
    end
  end

  // configuration registers and sticky events; a set beats a clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvConfig_q            <= `NV_FACTORY_VALUE;
      factory_q             <= 1'b1;
      otwEnable_q           <= 1'b0;
      spifEnable_q          <= 1'b0;
      supCtrl_q             <= 3'h0;
      overtempWarningStatus <= 1'b0;
      overtempWarningEvent  <= 1'b0;
      spiFailureEvent       <= 1'b0;
    end else begin
      if (writeStrobe && spiActive) begin
        case (frameAddr)
          `ADDR_EVENT_ENABLE: begin
            otwEnable_q  <= writeData[`EVT_OTW_BIT];
            spifEnable_q <= writeData[`EVT_SPI_FAILURE_EVENT_BIT];
          end
          `ADDR_SUPPLY_CTRL: supCtrl_q <= writeData[2:0];
          `ADDR_NV_CONFIG: begin
            if (factory_q) begin
              nvConfig_q <= writeData;
              factory_q  <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      overtempWarningStatus <= warnSync[1];
      if (warnSync[1] && !overtempWarningStatus && otwEnable_q)
        overtempWarningEvent <= 1'b1;
      else if (writeStrobe && spiActive &&
               frameAddr == `ADDR_EVENT_STATUS &&
               writeData[`EVT_OTW_BIT])
        overtempWarningEvent <= 1'b0;
      if (sleepFail)
        spiFailureEvent <= 1'b1;
      else if (writeStrobe && spiActive &&
               frameAddr == `ADDR_EVENT_STATUS &&
               writeData[`EVT_SPI_FAILURE_EVENT_BIT])
        spiFailureEvent <= 1'b0;
    end
  end

  // aux supply decode from control bits
  assign supRequest =
    (supCtrl_q[`SUP_CTRL_MSB:`SUP_CTRL_LSB] == `SUP_CTRL_ALWAYS) ||
    (supCtrl_q[`SUP_CTRL_MSB:`SUP_CTRL_LSB] == `SUP_CTRL_ACTIVE &&
     mode_q != `ST_SLEEP) ||
    (supCtrl_q[`SUP_CTRL_MSB:`SUP_CTRL_LSB] == `SUP_CTRL_NORMAL &&
     mode_q == `ST_NORMAL) ||
    (supCtrl_q[`SUP_STARTUP_BIT] && mode_q == `ST_RESET && powerUp_q);

  // reset line is open drain: driven low outside the awake modes, except in reset once the pulse is done
  assign resetLineOut = 1'b0;
  // reset line low in off, sleep, overtemp and in reset until the pulse is done
  assign resetLineOe  = !(spiActive || (mode_q == `ST_RESET && pulseDone_q));

  // per-mode outputs, registered
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mcuRegulatorEn   <= 1'b0;
      auxSupplyEn      <= 1'b0;
      canTxEnable      <= 1'b0;
      canRxEnable      <= 1'b0;
      canBusRelease    <= 1'b1;
      receiveLine      <= 1'b1;
      watchdogEnable   <= 1'b0;
      watchdogWindowEn <= 1'b0;
      operatingMode    <= `ST_OFF;
    end else begin
      operatingMode    <= mode_q;
      // regulator off in overtemp, also off and sleep
      mcuRegulatorEn   <= !(mode_q == `ST_OFF || mode_q == `ST_SLEEP ||
                            mode_q == `ST_OTEMP);
      // forced normal supplies and transceiver on
      auxSupplyEn      <= (mode_q == `ST_FORCED) ||
                          (mode_q != `ST_OFF && mode_q != `ST_OTEMP &&
                           supRequest);
      // transmitter kept through reset from forced normal
      canTxEnable      <= (mode_q == `ST_FORCED) ||
                          (mode_q == `ST_NORMAL) ||
                          (mode_q == `ST_RESET && fromForced_q &&
                           !canUvSync[1]);
      canRxEnable      <= (mode_q == `ST_FORCED) || (mode_q == `ST_NORMAL);
      canBusRelease    <= (mode_q == `ST_OFF) || (mode_q == `ST_OTEMP);
      // pending wake holds receive line low outside off, normal and forced normal
      receiveLine      <= (mode_q == `ST_FORCED || mode_q == `ST_NORMAL) ?
                          canRxBit : !(pendSync[1] && mode_q != `ST_OFF);
      // watchdog only in standby, normal, sleep
      watchdogEnable   <= (mode_q == `ST_STANDBY) ||
                          (mode_q == `ST_NORMAL) || (mode_q == `ST_SLEEP);
      watchdogWindowEn <= (mode_q == `ST_NORMAL);
    end
  end

endmodule

// ===== sbc_mode_sva.sv
// port assertions for the operating mode controller
`timescale 1ns/1ps
module sbc_mode_sva #(
  parameter STARTUP_CYC = 50
) (
  input wire       clk,
  input wire       resetn,
  input wire       batteryAbovePowerOn,
  input wire       batteryBelowPowerOff,
  input wire       tempAboveWarning,
  input wire       tempAboveShutdown,
  input wire       mcuRegulatorEn,
  input wire       auxSupplyEn,
  input wire       canTxEnable,
  input wire       canRxEnable,
  input wire       canBusRelease,
  input wire       resetLineOe,
  input wire       watchdogEnable,
  input wire       watchdogWindowEn,
  input wire [2:0] operatingMode,
  input wire       overtempWarningStatus,
  input wire       overtempWarningEvent
);
  reg [31:0] upCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // raw run of the power-on level; input sync only makes it longer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) upCnt <= 32'h0;
    else upCnt <= batteryAbovePowerOn ? upCnt + 32'h1 : 32'h0;
  end
  chk_startup_time: assert property (
    $past(operatingMode) == 3'h0 && operatingMode != 3'h0 |->
    operatingMode == 3'h1 && upCnt >= STARTUP_CYC) else $error("bad boot");
  chk_battery_off: assert property (
    batteryBelowPowerOff |-> ##[1:8] operatingMode == 3'h0)
    else $error("no off mode");
  chk_off_release: assert property (
    $stable(operatingMode) && operatingMode == 3'h0 |->
    canBusRelease && !mcuRegulatorEn && !canTxEnable)
    else $error("off outputs");
  chk_otemp_entry: assert property (
    tempAboveShutdown && !batteryBelowPowerOff &&
    operatingMode inside {3'h1, 3'h2, 3'h3, 3'h5} |->
    ##[1:8] operatingMode == 3'h6) else $error("no overtemp");
  chk_otemp_out: assert property (
    $stable(operatingMode) && operatingMode == 3'h6 |-> !mcuRegulatorEn
    && resetLineOe && !auxSupplyEn && !canTxEnable && !canRxEnable)
    else $error("overtemp outputs");
  chk_forced_out: assert property (
    $stable(operatingMode) && operatingMode == 3'h5 |->
    mcuRegulatorEn && auxSupplyEn && canTxEnable && canRxEnable)
    else $error("forced outputs");
  chk_wdog_window: assert property (
    $stable(operatingMode) && operatingMode != 3'h3 |-> !watchdogWindowEn)
    else $error("window outside normal");
  chk_wdog_off: assert property (
    $stable(operatingMode) && operatingMode inside {3'h0, 3'h1, 3'h5, 3'h6}
    |-> !watchdogEnable) else $error("watchdog on");
  chk_warn_level: assert property (
    $rose(tempAboveWarning) |-> ##[1:5] overtempWarningStatus)
    else $error("no warning");
  chk_warn_event: assert property (
    $rose(overtempWarningEvent) |-> overtempWarningStatus)
    else $error("stray warning event");
endmodule
bind sbc_operating_mode_controller sbc_mode_sva #(
  .STARTUP_CYC(STARTUP_CYC)) chk (.*);

// ===== host_mcu_model.sv
// host microcontroller: serial master and reset wire partner
`timescale 1ns/1ps
module host_mcu_model (
  input  wire clk,
  input  wire sdo,
  input  wire resetLineOe,
  output reg  sck,
  output reg  sdi,
  output reg  csn,
  output wire resetLineIn
);
  reg pullLow;
  // open-drain wire with pull-up: low while either side pulls
  assign resetLineIn = ~(resetLineOe | pullLow);
  // idle levels
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    csn = 1'b1;
    pullLow = 1'b0;
  end
  task xfer(input [15:0] frm, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      @(negedge clk) csn = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        sdi = frm[i];
        repeat (4) @(negedge clk);
        sck = 1'b1;
        if (i < 8) rd[i] = sdo;
        repeat (4) @(negedge clk);
        sck = 1'b0;
      end
      repeat (4) @(negedge clk);
      csn = 1'b1;
      // a released line must not keep showing the last bit
      sdi = ~sdi;
      repeat (8) @(negedge clk);
    end
  endtask
endmodule

// ===== testbench.sv
// self-checking bench for the operating mode controller
`timescale 1ns/1ps
module testbench;
  reg        clk = 1'b0, resetn = 1'b0, batteryAbovePowerOn = 1'b0;
  reg        batteryBelowPowerOff = 1'b0, tempAboveWarning = 1'b0;
  reg        tempAboveShutdown = 1'b0, tempBelowRelease = 1'b0;
  reg        v1Undervoltage = 1'b0, canSupplyUndervoltage = 1'b0;
  reg        wakeRegular = 1'b0, wakeDiagnostic = 1'b0, canRxBit = 1'b0;
  reg        wakePending = 1'b0, wakeSourceEnabled = 1'b1;
  reg  [7:0] rd;
  reg  [8:0] rows [0:4];
  integer    n_mismatch = 0, check_count = 0, k;
  wire       sck, sdi, csn, sdo, resetLineIn, resetLineOe, receiveLine;
  wire       mcuRegulatorEn, auxSupplyEn, canTxEnable, canRxEnable;
  wire       canBusRelease, watchdogEnable, watchdogWindowEn;
  wire       overtempWarningStatus, overtempWarningEvent, spiFailureEvent;
  wire [2:0] operatingMode;
  // short startup count keeps the run brief
  sbc_operating_mode_controller #(.STARTUP_CYC(50)) DUT (
    .resetLineOut(),
    .*
  );
  host_mcu_model host (.*);
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // bounded wait for a mode, then let the outputs settle
  task waitMode(input [2:0] m, input integer lim);
    integer i;
    begin
      i = 0;
      while (operatingMode !== m && i < lim) begin
        @(negedge clk);
        i = i + 1;
      end
      chk({5'h00, operatingMode}, {5'h00, m});
      if (operatingMode !== m) close_out;
      else repeat (3) @(negedge clk);
    end
  endtask
  task endT(input [63:0] nm);
    $display("test %0s done", nm);
  endtask
  initial begin
    // mode code, expected mode, expected read-back code
    rows[0] = {3'h7, 3'h3, 3'h7};
    rows[1] = {3'h6, 3'h3, 3'h7};
    rows[2] = {3'h4, 3'h2, 3'h4};
    rows[3] = {3'h5, 3'h2, 3'h4};
    rows[4] = {3'h7, 3'h3, 3'h7};
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    chk({6'h00, canBusRelease, mcuRegulatorEn}, 8'h02);
    batteryAbovePowerOn = 1'b1;
    waitMode(3'h1, 200);
    waitMode(3'h5, 3000);
    chk({4'h0, mcuRegulatorEn, auxSupplyEn, canTxEnable, watchdogEnable},
        8'h0E);
    host.xfer(16'h0300, rd);
    chk(rd, 8'h00);
    host.xfer(16'hE900, rd);
    chk(rd, 8'h01);
    host.xfer(16'hE800, rd);
    host.xfer(16'hE801, rd);
    host.xfer(16'hE900, rd);
    chk(rd, 8'h00);
    endT("forced");
    host.pullLow = 1'b1;
    waitMode(3'h1, 50);
    chk({7'h00, canTxEnable}, 8'h01);
    host.pullLow = 1'b0;
    waitMode(3'h2, 3000);
    host.xfer(16'h0300, rd);
    chk(rd, 8'h04);
    for (k = 0; k < 5; k = k + 1) begin
      host.xfer({8'h02, 5'h00, rows[k][8:6]}, rd);
      repeat (4) @(negedge clk);
      chk({5'h00, operatingMode}, {5'h00, rows[k][5:3]});
      host.xfer(16'h0300, rd);
      chk(rd, {5'h00, rows[k][2:0]});
    end
    endT("modes");
    wakePending = 1'b1;
    host.xfer(16'h0201, rd);
    waitMode(3'h1, 50);
    waitMode(3'h2, 3000);
    wakePending = 1'b0;
    host.xfer(16'h0700, rd);
    chk(rd, 8'h14);
    host.xfer(16'h0201, rd);
    waitMode(3'h4, 50);
    chk({7'h00, mcuRegulatorEn}, 8'h00);
    wakeRegular = 1'b1;
    waitMode(3'h1, 50);
    wakeRegular = 1'b0;
    waitMode(3'h2, 3000);
    endT("sleep");
    wakePending = 1'b1;
    tempAboveShutdown = 1'b1;
    waitMode(3'h6, 20);
    chk({2'h0, mcuRegulatorEn, resetLineOe, auxSupplyEn, canTxEnable,
        canRxEnable, receiveLine}, 8'h10);
    tempAboveShutdown = 1'b0;
    tempBelowRelease = 1'b1;
    waitMode(3'h1, 20);
    tempBelowRelease = 1'b0;
    waitMode(3'h2, 3000);
    chk({7'h00, receiveLine}, 8'h00);
    wakePending = 1'b0;
    endT("otemp");
    tempAboveWarning = 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h00, overtempWarningStatus, overtempWarningEvent}, 8'h02);
    tempAboveWarning = 1'b0;
    host.xfer(16'h0804, rd);
    tempAboveWarning = 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h00, overtempWarningStatus, overtempWarningEvent}, 8'h03);
    batteryBelowPowerOff = 1'b1;
    waitMode(3'h0, 20);
    chk({7'h00, canBusRelease}, 8'h01);
    endT("power");
    // second reset in mid-run: factory state again, then boot anew
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk({1'b0, overtempWarningStatus, overtempWarningEvent, operatingMode,
        canBusRelease, resetLineOe}, 8'h03);
    batteryBelowPowerOff = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    waitMode(3'h1, 200);
    waitMode(3'h5, 3000);
    // sleep inhibit set, forced normal cleared
    host.xfer(16'hE804, rd);
    host.pullLow = 1'b1;
    waitMode(3'h1, 50);
    host.pullLow = 1'b0;
    waitMode(3'h2, 3000);
    host.xfer(16'h0201, rd);
    chk({3'h0, auxSupplyEn, spiFailureEvent, operatingMode}, 8'h0A);
    host.xfer(16'h2006, rd);
    host.xfer(16'hC202, rd);
    chk({6'h00, auxSupplyEn, spiFailureEvent}, 8'h02);
    endT("restart");
    close_out;
  end
endmodule
